// [common/sidp_pkg.sv]
// shared constants and carriers for the stepper input decode and program block
// assumes one 40 MHz clock and inputs already synchronous to it
package sidp_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 25000;
	localparam int PROG_MIN_PS   = 200000;
	localparam int PROG_MIN_CYC  = (PROG_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ****************************************
	// configuration register layout
	// ****************************************
	localparam int          CFG_W        = 6;
	localparam logic [5:0]  CFG_RST      = 6'h00;
	localparam int          CFG_LVL_LO   = 0;
	localparam int          CFG_LVL_HI   = 1;
	localparam int          CFG_TON_LO   = 2;
	localparam int          CFG_TON_HI   = 3;
	localparam int          CFG_HALF_BIT = 4;
	localparam int          CFG_FULL_BIT = 5;

	// ****************************************
	// decoded percentages
	// ****************************************
	localparam logic [6:0] TON_PCT_00  = 7'h4B;
	localparam logic [6:0] TON_PCT_C3  = 7'h32;
	localparam logic [6:0] TON_PCT_C2  = 7'h64;
	localparam logic [6:0] TON_PCT_OFF = 7'h00;
	localparam logic [6:0] LVL_PCT_00  = 7'h28;
	localparam logic [6:0] LVL_PCT_C0  = 7'h46;
	localparam logic [6:0] LVL_PCT_C1  = 7'h37;
	localparam logic [6:0] LVL_PCT_11  = 7'h55;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [3:0] phase;
		logic       reduceSel;
		logic       loopSel;
	} sidp_in_t;

	typedef struct packed {
		logic [3:0] sinkOn;
		logic       outEnable;
		logic       reduceFlag;
		logic       openLoop;
		logic       halfFreq;
		logic [6:0] onTimePct;
		logic [6:0] levelPct;
	} sidp_ctl_t;

	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_QUAL = 3'b010,
		ST_HELD = 3'b100
	} sidp_state_t;

endpackage : sidp_pkg

// [dv/sidp_host_model.sv]
// controller model that drives the phase and select inputs
// assumes the bench clock; pins change only just after rising edges
`timescale 1ns/1ps
module sidp_host_model
	import sidp_pkg::*;
(
	// clock
	input  wire logic          clk,
	// controller outputs
	output sidp_pkg::sidp_in_t pins
);
	initial pins = '{4'hF, 1'b0, 1'b0};

	task automatic setPins(input logic [3:0] ph, input logic r, input logic l);
		@(posedge clk);
		pins <= '{ph, r, l};
	endtask : setPins

	// one bit per low gap, so program mode is left between bits
	task automatic sendBit(input logic r, input logic l, input int n);
		setPins(4'hF, r, l);
		setPins(4'h0, r, l);
		repeat (n - 1) @(posedge clk);
		setPins(4'hF, r, l);
	endtask : sendBit
endmodule : sidp_host_model

// [dv/test_sidp_top.sv]
// self-checking bench for the stepper input decode and program block
// assumes a shortened low qualification of three cycles
`timescale 1ns/1ps
module test_sidp_top;
	import sidp_pkg::*;
	localparam int LOWC = 3;
	logic      clk;
	logic      sysRst;
	sidp_in_t  pins;
	sidp_ctl_t ctl;
	logic [5:0] cfgBits;
	logic      progMode;
	int        miscompares = 0;
	int        cmpCount = 0;

	sidp_top #(.MIN_LOW_CYC(LOWC)) dut (.clk(clk), .sys_rst(sysRst), .pins(pins),
		.ctl(ctl), .cfgBits(cfgBits), .progMode(progMode));
	sidp_host_model host (.clk(clk), .pins(pins));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic stop_test();
		$display("compares %0d miscompares %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic prog(input logic [5:0] v);
		for (int i = 5; i >= 0; i--) host.sendBit(v[i] ^ i[0], i[0], LOWC);
		#1;
		chk("cfgBits", {2'h0, cfgBits}, {2'h0, v});
	endtask : prog

	task automatic drive(input logic [3:0] ph, input logic r, input logic l);
		host.setPins(ph, r, l);
		@(posedge clk);
		#1;
	endtask : drive

	// short low gap: program mode but no shift; long gap: one shift
	task automatic t_gaps();
		drive(4'h0, 1'b1, 1'b0);
		chk("progMode", 8'(progMode), 8'h01);
		chk("outEnable", 8'(ctl.outEnable), 8'h00);
		chk("level70", 8'(ctl.levelPct), 8'h46);
		drive(4'hF, 1'b0, 1'b0);
		chk("progIdle", 8'(progMode), 8'h00);
		chk("cfgShort", 8'(cfgBits), 8'h2D);
		host.sendBit(1'b0, 1'b1, 8);
		#1;
		chk("cfgLong", 8'(cfgBits), 8'h1B);
		chk("level85", 8'(ctl.levelPct), 8'h55);
		chk("onTime50", 8'(ctl.onTimePct), 8'h32);
	endtask : t_gaps

	task automatic t_full();
		prog(6'h36);
		drive(4'h5, 1'b0, 1'b0);
		chk("sinkOn", 8'(ctl.sinkOn), 8'h0A);
		chk("enable", 8'(ctl.outEnable), 8'h01);
		chk("reduce", 8'(ctl.reduceFlag), 8'h00);
		chk("halfFreq", 8'(ctl.halfFreq), 8'h01);
		chk("level", 8'(ctl.levelPct), 8'h37);
		drive(4'h5, 1'b1, 1'b1);
		chk("reduceSel", 8'(ctl.reduceFlag), 8'h01);
		chk("openLoop", 8'(ctl.openLoop), 8'h01);
		chk("halfOpen", 8'(ctl.halfFreq), 8'h00);
		chk("onTime", 8'(ctl.onTimePct), 8'h64);
		drive(4'h3, 1'b0, 1'b0);
		chk("reducePair", 8'(ctl.reduceFlag), 8'h01);
		chk("disPair", 8'(ctl.outEnable), 8'h00);
		chk("sinkOff", 8'(ctl.sinkOn), 8'h00);
	endtask : t_full

	task automatic t_simple();
		prog(6'h0C);
		drive(4'hD, 1'b0, 1'b0);
		chk("sinkSimple", 8'(ctl.sinkOn), 8'h09);
		chk("enSimple", 8'(ctl.outEnable), 8'h01);
		chk("nominal", 8'(ctl.reduceFlag), 8'h00);
		chk("level40", 8'(ctl.levelPct), 8'h28);
		drive(4'h5, 1'b0, 1'b0);
		chk("reduceIn4", 8'(ctl.reduceFlag), 8'h01);
		drive(4'h9, 1'b0, 1'b0);
		chk("enLow", 8'(ctl.outEnable), 8'h00);
		drive(4'hD, 1'b0, 1'b1);
		chk("tonOff", 8'(ctl.outEnable), 8'h00);
	endtask : t_simple

	task automatic t_reset();
		@(posedge clk);
		sysRst <= 1'b1;
		@(posedge clk);
		sysRst <= 1'b0;
		#1;
		chk("cfgRst", 8'(cfgBits), 8'h00);
		chk("enRst", 8'(ctl.outEnable), 8'h00);
		drive(4'hD, 1'b0, 1'b1);
		chk("onTime75", 8'(ctl.onTimePct), 8'h4B);
		chk("enAfter", 8'(ctl.outEnable), 8'h01);
	endtask : t_reset

	initial begin
		sysRst = 1'b1;
		repeat (12) @(posedge clk);
		sysRst <= 1'b0;
		prog(6'h2D);
		t_gaps();
		t_full();
		t_simple();
		t_reset();
		stop_test();
	end
endmodule : test_sidp_top

// [verilog/sidp_top.sv]
// input decoding and serial configuration of a unipolar stepper driver
// assumes phase and select inputs synchronous to clk, reset synchronous
`timescale 1ns/1ps
module sidp_top
	import sidp_pkg::*;
#(
	parameter int MIN_LOW_CYC = sidp_pkg::PROG_MIN_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// controller inputs
	input  wire sidp_pkg::sidp_in_t pins,
	// decoded drive
	output sidp_pkg::sidp_ctl_t     ctl,
	output logic [5:0]              cfgBits,
	output logic                    progMode
);
	import sidp_pkg::*;

	// the 8-bit low counter and its last-count compare serve 2..255 only
	generate
		if (MIN_LOW_CYC < 2 || MIN_LOW_CYC > 255) begin : minLowCheck
			$error("MIN_LOW_CYC out of range");
		end
	endgenerate

	// ****************************************
	// program clock qualifier
	// ****************************************
	sidp_state_t state_r;
	sidp_state_t state_nxt;
	logic [7:0]  lowCnt_r;
	logic [7:0]  lowCnt_nxt;
	logic [5:0]  drive_config_shift_r;
	logic [5:0]  cfg_nxt;
	sidp_ctl_t   ctl_r;
	sidp_ctl_t   ctl_nxt;
	logic        prog_r;

	wire allLow     = (pins.phase == 4'h0);
	wire lastCnt    = (lowCnt_r == 8'(MIN_LOW_CYC - 1));
	wire shiftPulse = (state_r == ST_QUAL) && allLow && lastCnt;
	wire serialBit  = pins.reduceSel ^ pins.loopSel;

	always_comb begin
		state_nxt  = state_r;
		lowCnt_nxt = lowCnt_r;
		case (state_r)
			ST_WAIT: begin
				if (allLow) begin
					state_nxt  = ST_QUAL;
					lowCnt_nxt = 8'h01;
				end
			end
			ST_QUAL: begin
				if (!allLow) begin
					state_nxt = ST_WAIT;
				end else if (lastCnt) begin
					state_nxt = ST_HELD;
				end else begin
					lowCnt_nxt = lowCnt_r + 8'h01;
				end
			end
			ST_HELD: begin
				if (!allLow) begin
					state_nxt = ST_WAIT;
				end
			end
			default: begin
				state_nxt = ST_WAIT;
			end
		endcase
	end

	assign cfg_nxt = shiftPulse ? {drive_config_shift_r[4:0], serialBit}
	                            : drive_config_shift_r;

	// ****************************************
	// operating decode
	// ****************************************
	wire       fullMode  = drive_config_shift_r[CFG_FULL_BIT];
	wire       openLoop  = pins.loopSel;
	wire [1:0] tonCode   = {drive_config_shift_r[CFG_TON_HI], drive_config_shift_r[CFG_TON_LO]};
	wire [1:0] lvlCode   = {drive_config_shift_r[CFG_LVL_HI], drive_config_shift_r[CFG_LVL_LO]};
	wire       tonOff    = openLoop && (tonCode == 2'b11);
	wire [3:0] fullSink  = ~pins.phase;
	// phase A steers sinks 1/2, phase B sinks 3/4; only full-step patterns result
	wire [3:0] simpSink  = {~pins.phase[1], pins.phase[1],
	                        ~pins.phase[0], pins.phase[0]};
	wire       fullBad   = (pins.phase[1:0] == 2'b00) || (pins.phase[3:2] == 2'b00);
	wire       modeEn    = fullMode ? !fullBad : pins.phase[2];
	wire       fullRed   = (&pins.phase[1:0]) || (&pins.phase[3:2]) || pins.reduceSel;
	wire       simpRed   = !openLoop && (!pins.phase[3] || pins.reduceSel);

	function automatic logic [6:0] tonPct(input logic [1:0] code);
		case (code)
			2'b00:   tonPct = TON_PCT_00;
			2'b10:   tonPct = TON_PCT_C3;
			2'b01:   tonPct = TON_PCT_C2;
			default: tonPct = TON_PCT_OFF;
		endcase
	endfunction : tonPct

	function automatic logic [6:0] lvlPct(input logic [1:0] code);
		case (code)
			2'b00:   lvlPct = LVL_PCT_00;
			2'b01:   lvlPct = LVL_PCT_C0;
			2'b10:   lvlPct = LVL_PCT_C1;
			default: lvlPct = LVL_PCT_11;
		endcase
	endfunction : lvlPct

	always_comb begin
		ctl_nxt            = '0;
		ctl_nxt.openLoop   = openLoop;
		ctl_nxt.halfFreq   = !openLoop && drive_config_shift_r[CFG_HALF_BIT];
		ctl_nxt.onTimePct  = openLoop ? tonPct(tonCode) : TON_PCT_OFF;
		ctl_nxt.levelPct   = lvlPct(lvlCode);
		ctl_nxt.reduceFlag = fullMode ? fullRed : simpRed;
		ctl_nxt.outEnable  = !allLow && modeEn && !tonOff;
		ctl_nxt.sinkOn     = ctl_nxt.outEnable ? (fullMode ? fullSink : simpSink) : 4'h0;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r              <= ST_WAIT;
			lowCnt_r             <= 8'h00;
			drive_config_shift_r <= CFG_RST;
			ctl_r                <= '0;
			prog_r               <= 1'b0;
		end else begin
			state_r              <= state_nxt;
			lowCnt_r             <= lowCnt_nxt;
			drive_config_shift_r <= cfg_nxt;
			ctl_r                <= ctl_nxt;
			prog_r               <= allLow;
		end
	end

	assign ctl      = ctl_r;
	assign cfgBits  = drive_config_shift_r;
	assign progMode = prog_r;

	// ****************************************
	// assertions
	// ****************************************
	// helper: consecutive low samples seen, and a shot already spent in this gap
	logic [7:0] lowSeen_r;
	logic       gapShot_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lowSeen_r <= 8'h00;
			gapShot_r <= 1'b0;
		end else begin
			lowSeen_r <= !allLow ? 8'h00 : (lowSeen_r == 8'hFF) ? lowSeen_r : lowSeen_r + 8'h01;
			gapShot_r <= shiftPulse || (gapShot_r && allLow);
		end
	end

	sequence lowRun;
		allLow [*8];
	endsequence

	property pulseNeedsLow;
		@(posedge clk) disable iff (sys_rst) shiftPulse |-> $past(allLow, 1);
	endproperty

	// antecedents of shift_in_a, hold_cfg_a, full_map_a, simp_red_a and full_red_a skip the edge that applies a reset
	prog_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		allLow |=> !ctl.outEnable && ctl.sinkOn == 4'h0)
		else $error("outputs on in program mode");
	min_low_a: assert property (pulseNeedsLow)
		else $error("shift without low time");
	one_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
		gapShot_r |-> !shiftPulse)
		else $error("second pulse in one low gap");
	low_span_a: assert property (@(posedge clk) disable iff (sys_rst)
		shiftPulse |-> lowSeen_r >= 8'(MIN_LOW_CYC - 1))
		else $error("shift before full low time");
	long_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		(allLow && !gapShot_r && lowSeen_r == 8'(MIN_LOW_CYC - 1)) |-> shiftPulse)
		else $error("long low gap gave no shift");
	shift_in_a: assert property (@(posedge clk) disable iff (sys_rst)
		(shiftPulse && !sys_rst) |=> cfgBits == {$past(cfgBits[4:0]), $past(serialBit)})
		else $error("shift register load wrong");
	hold_cfg_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!shiftPulse && !sys_rst) |=> $stable(cfgBits))
		else $error("config changed without pulse");
	full_map_a: assert property (@(posedge clk) disable iff (sys_rst)
		(fullMode && !fullBad && !tonOff && !allLow && !sys_rst) |=>
			ctl.sinkOn == ~$past(pins.phase))
		else $error("full mode sink mapping wrong");
	full_bad_a: assert property (@(posedge clk) disable iff (sys_rst)
		(fullMode && fullBad) |=> !ctl.outEnable)
		else $error("prohibited state not disabled");
	simp_en_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!fullMode && !pins.phase[2]) |=> !ctl.outEnable)
		else $error("simplified enable ignored");
	ton_off_a: assert property (@(posedge clk) disable iff (sys_rst)
		(openLoop && tonCode == 2'b11) |=> !ctl.outEnable && ctl.onTimePct == TON_PCT_OFF)
		else $error("open loop disable code ignored");
	half_freq_a: assert property (@(posedge clk) disable iff (sys_rst)
		ctl.halfFreq |-> !ctl.openLoop)
		else $error("halving in open loop");
	simp_red_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!fullMode && !openLoop && !sys_rst) |=>
			ctl.reduceFlag == (!$past(pins.phase[3]) || $past(pins.reduceSel)))
		else $error("simplified reduction wrong");
	full_red_a: assert property (@(posedge clk) disable iff (sys_rst)
		(fullMode && pins.reduceSel && !sys_rst) |=> ctl.reduceFlag)
		else $error("full reduction missing");
	low_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		((state_r == ST_WAIT) and lowRun) |-> state_r != ST_WAIT || !allLow)
		else $error("qualifier stuck");

endmodule : sidp_top
